//--- rtl/sfr_defines.vh
// Overview of operation
// - only assigned bits have storage
// - power-up clear sets defaults; watchdog flag excluded
// - enable reg one at 00h, six enables
// - watchdog enable ignored in watchdog mode
// - enable reg two only bit 7
// - flag reg one at 02h, bits 5, 3 and 2 absent
// - serial tx flag set by power-up clear
// - serial rx flag set on reception
// - nonmaskable flag set by pin event
// - osc fault flag set on fault, resets set
// - watchdog flag on overflow in watchdog mode or bad key
// - watchdog flag cleared by power-on/pin reset or by a flag reg one write with bit 0 low
// - flag reg two bit 7 interval timer flag
// - module enable bit 7 async transmit enable
// - module enable bit 6 rx or sync txrx
// - no second module enable register
// - nmi sources gated by own enable only
`ifndef SFR_DEFINES_VH
`define SFR_DEFINES_VH
`define SFR_ADDR_IE1      4'h0
`define SFR_ADDR_IE2      4'h1
`define SFR_ADDR_INTERRUPT_FLAG_ONE     4'h2
`define SFR_ADDR_INTERRUPT_FLAG_TWO     4'h3
`define SFR_ADDR_ME1      4'h4
`define SFR_MASK_IE1      8'hf3
`define SFR_MASK_IE2      8'h80
`define SFR_MASK_INTERRUPT_FLAG_ONE     8'hd3
`define SFR_MASK_INTERRUPT_FLAG_TWO     8'h80
`define SFR_MASK_ME1      8'hc0
`define SFR_RST_IE1       8'h00
`define SFR_RST_IE2       8'h00
`define SFR_RST_INTERRUPT_FLAG_ONE      8'h82
`define SFR_RST_INTERRUPT_FLAG_TWO      8'h00
`define SFR_RST_ME1       8'h00
`define SFR_BIT_STX       7
`define SFR_BIT_SRX       6
`define SFR_BIT_FLV       5
`define SFR_BIT_NMI       4
`define SFR_BIT_OSC       1
`define SFR_BIT_WDT       0
`define SFR_BIT_BT        7
`endif

//--- rtl/sfr_sync2.v
`timescale 1ns/100ps
// two-flop synchroniser for pin-side levels
module sfr_sync2 #(
  parameter W = 1
) (
  input  wire         ref_clk_i,
  input  wire         rstn_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end
  assign q_o = sync_q;
endmodule // sfr_sync2

//--- rtl/sfr_byte_reg.v
`timescale 1ns/100ps
// byte register: present-bit mask, reset value on puc, write, hw set wins
module sfr_byte_reg #(
  parameter [7:0] MASK = 8'hff,
  parameter [7:0] RSTV = 8'h00,
  parameter [7:0] KEEP = 8'h00
) (
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  input  wire       puc_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  input  wire [7:0] set_i,
  output wire [7:0] q_o
);
  reg  [7:0] val_q;
  reg  [7:0] val_d;
  always @* begin
    val_d = val_q;
    if (puc_i)
      val_d = (RSTV & ~KEEP) | (val_q & KEEP);
    if (wr_i)
      val_d = wdata_i;
    val_d = (val_d | set_i) & MASK;
  end
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      val_q <= RSTV & MASK;
    else
      val_q <= val_d;
  end
  assign q_o = val_q;
endmodule // sfr_byte_reg

//--- rtl/sfr_bank.v
`timescale 1ns/100ps
`include "sfr_defines.vh"
module sfr_bank (
  // clock and power-on reset
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  // power-up clear and pin reset (same clock, one-cycle pulses)
  input  wire       power_up_clear_i,
  input  wire       pin_reset_i,
  // core bus
  input  wire [3:0] addr_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  // hardware set events
  input  wire       serial_tx_set_i,
  input  wire       serial_rx_set_i,
  input  wire       nmi_pin_evt_i,
  input  wire       osc_fault_i,
  input  wire       wdt_overflow_i,
  input  wire       wdt_key_viol_i,
  input  wire       wdt_interval_mode_i,
  input  wire       interval_timer_set_i,
  input  wire       flash_violation_i,
  // requests toward interrupt logic
  output reg        serial_tx_irq_o,
  output reg        serial_rx_irq_o,
  output reg        watchdog_irq_o,
  output reg        interval_timer_irq_o,
  output reg        nonmaskable_irq_o,
  // module enables
  output reg        async_tx_module_enable_o,
  output reg        rx_or_sync_module_enable_o
);
  ////////////////////////////////////////////////////////////////////////
  wire [7:0] ie1;
  wire [7:0] ie2;
  wire [7:0] interrupt_flag_one;
  wire [7:0] interrupt_flag_two;
  wire [7:0] me1;
  wire [1:0] pin_sync;
  reg        nmi_prev_q;
  wire       nmi_rise;
  wire       osc_rise;
  wire       wr_ie1;
  wire       wr_ie2;
  wire       wr_interrupt_flag_one;
  wire       wr_interrupt_flag_two;
  wire       wr_me1;
  wire [7:0] interrupt_flag_one_set;
  wire       wdt_rst;
  reg        wdt_flag_q;
  reg  [7:0] rdata_d;

  // pin-side levels pass two flops
  sfr_sync2 #(.W(2)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .d_i       ({nmi_pin_evt_i, osc_fault_i}),
    .q_o       (pin_sync)
  );

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nmi_prev_q <= 1'b0;
    end else begin
      nmi_prev_q <= pin_sync[1];
    end
  end
  assign nmi_rise = pin_sync[1] & ~nmi_prev_q;
  assign osc_rise = pin_sync[0];

  assign wr_ie1  = wr_i && (addr_i == `SFR_ADDR_IE1);
  assign wr_ie2  = wr_i && (addr_i == `SFR_ADDR_IE2);
  assign wr_interrupt_flag_one = wr_i && (addr_i == `SFR_ADDR_INTERRUPT_FLAG_ONE);
  assign wr_interrupt_flag_two = wr_i && (addr_i == `SFR_ADDR_INTERRUPT_FLAG_TWO);
  assign wr_me1  = wr_i && (addr_i == `SFR_ADDR_ME1);

  ////////////////////////////////////////////////////////////////////////
  sfr_byte_reg #(.MASK(`SFR_MASK_IE1), .RSTV(`SFR_RST_IE1)) u_ie1 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .puc_i     (power_up_clear_i),
    .wr_i      (wr_ie1),
    .wdata_i   (wdata_i),
    .set_i     (8'h00),
    .q_o       (ie1)
  );
  sfr_byte_reg #(.MASK(`SFR_MASK_IE2), .RSTV(`SFR_RST_IE2)) u_ie2 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .puc_i     (power_up_clear_i),
    .wr_i      (wr_ie2),
    .wdata_i   (wdata_i),
    .set_i     (8'h00),
    .q_o       (ie2)
  );

  // flags one excluding watchdog bit, which lives apart
  assign interrupt_flag_one_set = {serial_tx_set_i, serial_rx_set_i, 1'b0, nmi_rise,
                     2'b00, osc_rise, 1'b0};
  sfr_byte_reg #(.MASK(`SFR_MASK_INTERRUPT_FLAG_ONE & 8'hfe), .RSTV(`SFR_RST_INTERRUPT_FLAG_ONE)) u_interrupt_flag_one (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .puc_i     (power_up_clear_i),
    .wr_i      (wr_interrupt_flag_one),
    .wdata_i   (wdata_i),
    .set_i     (interrupt_flag_one_set),
    .q_o       (interrupt_flag_one)
  );
  sfr_byte_reg #(.MASK(`SFR_MASK_INTERRUPT_FLAG_TWO), .RSTV(`SFR_RST_INTERRUPT_FLAG_TWO)) u_interrupt_flag_two (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .puc_i     (power_up_clear_i),
    .wr_i      (wr_interrupt_flag_two),
    .wdata_i   (wdata_i),
    .set_i     ({interval_timer_set_i, 7'h00}),
    .q_o       (interrupt_flag_two)
  );
  sfr_byte_reg #(.MASK(`SFR_MASK_ME1), .RSTV(`SFR_RST_ME1)) u_me1 (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .puc_i     (power_up_clear_i),
    .wr_i      (wr_me1),
    .wdata_i   (wdata_i),
    .set_i     (8'h00),
    .q_o       (me1)
  );

  ////////////////////////////////////////////////////////////////////////
  // watchdog flag survives power-up clear
  assign wdt_rst = (wdt_overflow_i & ~wdt_interval_mode_i) | wdt_key_viol_i;
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      wdt_flag_q <= 1'b0;
    else if (wdt_rst)
      wdt_flag_q <= 1'b1;
    else if (wr_interrupt_flag_one)
      wdt_flag_q <= wdata_i[`SFR_BIT_WDT];
    else if (pin_reset_i)
      wdt_flag_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    rdata_d = 8'h00;
    case (addr_i)
      `SFR_ADDR_IE1:  rdata_d = ie1;
      `SFR_ADDR_IE2:  rdata_d = ie2;
      `SFR_ADDR_INTERRUPT_FLAG_ONE: rdata_d = {interrupt_flag_one[7:1], wdt_flag_q};
      `SFR_ADDR_INTERRUPT_FLAG_TWO: rdata_d = interrupt_flag_two;
      `SFR_ADDR_ME1:  rdata_d = me1;
      default:        rdata_d = 8'h00;
    endcase
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o                    <= 8'h00;
      serial_tx_irq_o            <= 1'b0;
      serial_rx_irq_o            <= 1'b0;
      watchdog_irq_o             <= 1'b0;
      interval_timer_irq_o       <= 1'b0;
      nonmaskable_irq_o          <= 1'b0;
      async_tx_module_enable_o   <= 1'b0;
      rx_or_sync_module_enable_o <= 1'b0;
    end else begin
      if (rd_i)
        rdata_o <= rdata_d;
      serial_tx_irq_o <= interrupt_flag_one[`SFR_BIT_STX] & ie1[`SFR_BIT_STX];
      serial_rx_irq_o <= interrupt_flag_one[`SFR_BIT_SRX] & ie1[`SFR_BIT_SRX];
      watchdog_irq_o  <= wdt_flag_q & ie1[`SFR_BIT_WDT] & wdt_interval_mode_i;
      interval_timer_irq_o <= interrupt_flag_two[`SFR_BIT_BT] & ie2[`SFR_BIT_BT];
      nonmaskable_irq_o <= (interrupt_flag_one[`SFR_BIT_NMI] & ie1[`SFR_BIT_NMI]) |
                           (interrupt_flag_one[`SFR_BIT_OSC] & ie1[`SFR_BIT_OSC]) |
                           (flash_violation_i & ie1[`SFR_BIT_FLV]);
      async_tx_module_enable_o   <= me1[7];
      rx_or_sync_module_enable_o <= me1[6];
    end
  end
endmodule // sfr_bank

//--- dv/sfb_monitor.sv
`timescale 1ns/100ps
module sfb_monitor (
  // clock, reset, clear
  input wire       ref_clk_i,
  input wire       rstn_i,
  input wire       power_up_clear_i,
  // bus
  input wire [3:0] addr_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] wdata_i,
  input wire [7:0] rdata_o,
  // watchdog and enables
  input wire       wdt_interval_mode_i,
  input wire       watchdog_irq_o,
  input wire       async_tx_module_enable_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  AST_RD_HOLE: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_IE1_HOLE: assert property (rd_i && addr_i == 4'h0 |=> rdata_o[3:2] == 2'h0)
    else $error("enable one absent bits set");
  AST_IE2_HOLE: assert property (rd_i && addr_i == 4'h1 |=> rdata_o[6:0] == 7'h00)
    else $error("enable two absent bits set");
  AST_INTERRUPT_FLAG_ONE_HOLE: assert property (rd_i && addr_i == 4'h2 |=> (rdata_o & 8'h2c) == 8'h00)
    else $error("flag one absent bits set");
  AST_INTERRUPT_FLAG_TWO_HOLE: assert property (rd_i && addr_i == 4'h3 |=> rdata_o[6:0] == 7'h00)
    else $error("flag two absent bits set");
  AST_ME_HOLE: assert property (rd_i && addr_i == 4'h4 |=> rdata_o[5:0] == 6'h00)
    else $error("module enable absent bits set");
  AST_ME_SET: assert property (wr_i && addr_i == 4'h4 && wdata_i[7] && !power_up_clear_i
    |-> ##[1:3] async_tx_module_enable_o)
    else $error("transmit enable not set");
  AST_PUC_ME: assert property (power_up_clear_i && !wr_i |-> ##[1:3] !async_tx_module_enable_o)
    else $error("clear left transmit enable");
  AST_WDT_MODE: assert property (!wdt_interval_mode_i [*3] |-> !watchdog_irq_o)
    else $error("watchdog request in watchdog mode");
  cover property (rd_i && addr_i == 4'h2);
  cover property (async_tx_module_enable_o);
  cover property (watchdog_irq_o);
endmodule // sfb_monitor
bind sfr_bank sfb_monitor i_mon (.ref_clk_i, .rstn_i, .power_up_clear_i, .addr_i, .wr_i,
  .rd_i, .wdata_i, .rdata_o, .wdt_interval_mode_i, .watchdog_irq_o, .async_tx_module_enable_o);

//--- dv/sfb_core.sv
`timescale 1ns/100ps
module sfb_core (
  // clock and read data
  input  wire       ref_clk_i,
  input  wire [7:0] rdata_i,
  // bus requests
  output reg  [3:0] addr_o,
  output reg        wr_o,
  output reg        rd_o,
  output reg  [7:0] wdata_o
);
  initial begin
    {addr_o, wr_o, rd_o, wdata_o} = 14'h0000;
  end
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(negedge ref_clk_i);
      {addr_o, wdata_o, wr_o} = {a, d, 1'b1};
      @(negedge ref_clk_i);
      {wdata_o, wr_o} = {~d, 1'b0};
    end
  endtask
  task rd(input [3:0] a, output [7:0] q);
    begin
      @(negedge ref_clk_i);
      {addr_o, rd_o} = {a, 1'b1};
      @(negedge ref_clk_i);
      rd_o = 1'b0;
      q = rdata_i;
    end
  endtask
endmodule // sfb_core

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  reg         ref_clk_i = 0, rstn_i = 0, power_up_clear_i = 0, pin_reset_i = 0;
  reg         osc_fault_i = 0, wdt_interval_mode_i = 1, flash_violation_i = 0;
  reg  [5:0]  ev = 0;
  wire [3:0]  addr;
  wire [7:0]  wdata, rdata, q0;
  wire        wr, rd;
  wire [4:0]  irq;
  wire [1:0]  me;
  integer     err_count = 0, samples_checked = 0, seed = 37265, i, a;
  reg  [7:0]  q, m [0:7], mk [0:7], sb [0:5];
  always #2 ref_clk_i = ~ref_clk_i;
  sfb_core i_core (.ref_clk_i, .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));
  sfr_bank i_dut (.ref_clk_i, .rstn_i, .power_up_clear_i, .pin_reset_i, .addr_i(addr),
    .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .serial_tx_set_i(ev[0]),
    .serial_rx_set_i(ev[1]), .wdt_overflow_i(ev[2]), .wdt_key_viol_i(ev[3]),
    .interval_timer_set_i(ev[4]), .nmi_pin_evt_i(ev[5]), .osc_fault_i,
    .wdt_interval_mode_i, .flash_violation_i, .serial_tx_irq_o(irq[0]),
    .serial_rx_irq_o(irq[1]), .watchdog_irq_o(irq[2]), .interval_timer_irq_o(irq[3]),
    .nonmaskable_irq_o(irq[4]), .async_tx_module_enable_o(me[1]),
    .rx_or_sync_module_enable_o(me[0]));
  task close_out;
    begin
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task ck(input [31:0] n, input [7:0] e, input [7:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        $display("[ERR] %s expected %h seen %h", n, e, s);
        err_count = err_count + 1;
      end
    end
  endtask
  task w(input [3:0] ad, input [7:0] d);
    begin
      i_core.wr(ad, d);
      if (ad < 5) m[ad] = d & mk[ad];
    end
  endtask
  task r(input [3:0] ad);
    begin
      i_core.rd(ad, q);
      ck("reg", m[ad], q);
    end
  endtask
  task wt;
    repeat (5) @(negedge ref_clk_i);
  endtask
  initial begin
    {mk[0], mk[1], mk[2], mk[3], mk[4], mk[5], mk[6], mk[7]} = 64'hf380d380c0000000;
    {m[0], m[1], m[2], m[3], m[4], m[5], m[6], m[7]} = 64'h0000820000000000;
    {sb[0], sb[1], sb[2], sb[3], sb[4], sb[5]} = 48'h804000018010;
    repeat (8) @(negedge ref_clk_i);
    rstn_i = 1;
    for (i = 0; i < 8; i = i + 1) r(i);
    for (i = 0; i < 40; i = i + 1) begin
      a = {$random(seed)} % 8;
      w(a, $random(seed));
      r(a);
    end
    w(2, 0);
    w(3, 0);
    for (i = 0; i < 6; i = i + 1) begin
      @(negedge ref_clk_i) ev[i] = 1;
      @(negedge ref_clk_i) ev[i] = 0;
      wt;
      m[i == 4 ? 3 : 2] = m[i == 4 ? 3 : 2] | sb[i];
      r(2);
      r(3);
    end
    w(2, 0);
    wdt_interval_mode_i = 0;
    @(negedge ref_clk_i) ev[2] = 1;
    @(negedge ref_clk_i) ev[2] = 0;
    osc_fault_i = 1;
    wt;
    osc_fault_i = 0;
    m[2] = 8'h03;
    r(2);
    fork
      begin @(negedge ref_clk_i) ev[1] = 1; @(negedge ref_clk_i) ev[1] = 0; end
      i_core.wr(2, 0);
    join
    m[2] = 8'h40;
    r(2);
    w(0, 8'hf3);
    w(4, 8'hc0);
    wt;
    ck("me", 8'h03, me);
    w(2, 8'h01);
    @(negedge ref_clk_i) power_up_clear_i = 1;
    @(negedge ref_clk_i) power_up_clear_i = 0;
    {m[0], m[1], m[2], m[3], m[4]} = 40'h0000830000;
    for (i = 0; i < 5; i = i + 1) r(i);
    @(negedge ref_clk_i) pin_reset_i = 1;
    @(negedge ref_clk_i) pin_reset_i = 0;
    m[2] = 8'h82;
    r(2);
    wdt_interval_mode_i = 1;
    w(0, 8'hf3);
    w(1, 8'h80);
    w(2, 8'hd3);
    w(3, 8'h80);
    wt;
    ck("irq", 8'h1f, irq);
    wdt_interval_mode_i = 0;
    wt;
    ck("irq", 8'h1b, irq);
    w(2, 0);
    w(0, 8'h20);
    flash_violation_i = 1;
    wt;
    ck("irq", 8'h18, irq);
    close_out;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    close_out;
  end
endmodule // tb_top
